/* logic/smb_pkg.sv */
// Shared constants and types for the system memory bus decoder
package smb_pkg;
  // Region bases; banks step on 16 MB boundaries (address bits 31:24)
  localparam logic [31:0] ROM_BASE       = 32'h0000_0000;
  localparam logic [31:0] FUNC_BASE      = 32'h1000_0000;
  localparam logic [31:0] IO_BASE        = 32'h2000_0000;
  localparam logic [31:0] DMA_IO_BASE    = 32'h2600_0000;
  localparam logic [31:0] SRAM_BASE      = 32'h3000_0000;
  localparam logic [31:0] USB_CSR_BASE   = 32'h3800_0000;
  localparam logic [31:0] USB_PLUG_BASE  = 32'h3900_0000;
  localparam logic [31:0] USB_PLUG_LAST  = 32'h3900_03FF;
  localparam logic [31:0] SDRAM_BASE     = 32'h4000_0000;
  localparam logic [31:0] SDRAM_MIR_BASE = 32'h8000_0000;
  localparam logic [31:0] MAC_BASE       = 32'hC000_0000;
  localparam logic [31:0] MAC_LAST       = 32'hC000_07FF;
  localparam logic [7:0]  ROM_BANKS      = 8'h04;
  localparam logic [7:0]  IO_BANKS       = 8'h06;
  localparam logic [7:0]  DMA_IO_BANKS   = 8'h04;
  localparam logic [7:0]  SRAM_BANKS     = 8'h03;
  // SDRAM geometry: 4 arrays of 16 MB give 64 MB in total
  localparam int          DRAM_MAX_MB    = 64;
  localparam int          ARRAY_LSB      = 28;
  localparam int          BANK_LSB       = 22;
  localparam int          ROW_LSB        = 10;
  localparam int          COL_LSB        = 2;
  localparam int          USB_ADDR_BIT   = 11;
  localparam logic [3:0]  USB_RX_DQM     = 4'h7;
  // Timing input fields: [3:0] activate-to-column wait, [7:4] read latency
  localparam int          TIM_RCD_LSB    = 0;
  localparam int          TIM_CL_LSB     = 4;
  // Peripheral strobe length in cycles
  localparam logic [3:0]  STROBE_CYC     = 4'h2;
  localparam logic [31:0] RDATA_RST      = 32'h0000_0000;

  typedef enum logic [3:0] {
    RGN_NONE, RGN_ROM, RGN_FUNC, RGN_IO, RGN_DMA, RGN_SRAM,
    RGN_USB_CSR, RGN_USB_PLUG, RGN_MAC, RGN_SDRAM
  } smb_region_t;

  typedef enum {
    ST_IDLE, ST_CS, ST_STROBE, ST_ACT, ST_RCD, ST_COL, ST_CAS, ST_PRE, ST_DONE
  } smb_state_t;
endpackage : smb_pkg

/* logic/smb_decode.sv */
// System memory bus decoder with flash, peripheral and SDRAM sequencing
module smb_decode (
  input  wire logic        i_clock,
  input  wire logic        i_nrst,
  input  wire logic        i_req,
  input  wire logic        i_we,
  input  wire logic [31:0] i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_be,
  output logic             o_ack,
  output logic      [31:0] o_rdata,
  input  wire logic [7:0]  i_dram_timing,
  input  wire logic        i_usb_rx_req,
  input  wire logic [23:0] i_usb_rx_addr,
  output logic             o_usb_rx_done,
  input  wire logic        i_usb_irq,
  output logic             o_external_irq_line_1,
  output logic      [3:0]  o_rom_bank_select_n,
  output logic             o_func_block_select,
  output logic      [5:0]  o_io_bank_select_n,
  output logic      [3:0]  o_dma_io_select_n,
  output logic      [2:0]  o_sram_select_n,
  output logic             o_usb_csr_select_n,
  output logic             o_usb_plug_select_n,
  output logic             o_mac_select_n,
  output logic             o_rd_n,
  output logic             o_wr_n,
  output logic      [23:0] o_periph_addr,
  output logic      [31:0] o_periph_wdata,
  input  wire logic [31:0] i_periph_rdata,
  output logic      [3:0]  o_sdram_cs_n,
  output logic             o_ras_n,
  output logic             o_cas_n,
  output logic             o_dram_write_strobe_n,
  output logic             o_dram_output_strobe_n,
  output logic      [3:0]  o_dqm,
  output logic      [11:0] o_dram_addr_bus,
  output logic      [1:0]  o_dram_ba,
  output logic      [31:0] o_dram_data_bus,
  output logic             o_dram_data_oe_n,
  input  wire logic [31:0] i_dram_data_bus
);

  smb_pkg::smb_state_t  state_q;
  smb_pkg::smb_region_t rgn_d;
  smb_pkg::smb_region_t rgn_q;
  logic [2:0]           idx_d;
  logic [2:0]           idx_q;
  logic [7:0]           top;
  logic [31:0]          addr_q;
  logic [31:0]          wdata_q;
  logic [3:0]           be_q;
  logic                 we_q;
  logic                 usb_q;
  logic [7:0]           tim_q;
  logic [3:0]           cnt_q;
  logic [31:0]          rdata_q;
  logic                 irq_q;
  logic                 periph;

  // Region decode on the top address byte, whole address for USB plug and MAC; gaps fall to RGN_NONE
  assign top = i_addr[31:24];
  always_comb
  begin
    rgn_d = smb_pkg::RGN_NONE;
    idx_d = 3'h0;
    if (top < smb_pkg::ROM_BASE[31:24] + smb_pkg::ROM_BANKS)
    begin
      rgn_d = smb_pkg::RGN_ROM;
      idx_d = 3'(top - smb_pkg::ROM_BASE[31:24]);
    end
    else if (top[7:4] == smb_pkg::FUNC_BASE[31:28])
      rgn_d = smb_pkg::RGN_FUNC;
    else if (top >= smb_pkg::IO_BASE[31:24] && top < smb_pkg::DMA_IO_BASE[31:24])
    begin
      rgn_d = smb_pkg::RGN_IO;
      idx_d = 3'(top - smb_pkg::IO_BASE[31:24]);
    end
    else if (top >= smb_pkg::DMA_IO_BASE[31:24]
             && top < smb_pkg::DMA_IO_BASE[31:24] + smb_pkg::DMA_IO_BANKS)
    begin
      rgn_d = smb_pkg::RGN_DMA;
      idx_d = 3'(top - smb_pkg::DMA_IO_BASE[31:24]);
    end
    else if (top >= smb_pkg::SRAM_BASE[31:24]
             && top < smb_pkg::SRAM_BASE[31:24] + smb_pkg::SRAM_BANKS)
    begin
      rgn_d = smb_pkg::RGN_SRAM;
      idx_d = 3'(top - smb_pkg::SRAM_BASE[31:24]);
    end
    else if (top == smb_pkg::USB_CSR_BASE[31:24])
      rgn_d = smb_pkg::RGN_USB_CSR;
    else if (i_addr >= smb_pkg::USB_PLUG_BASE && i_addr <= smb_pkg::USB_PLUG_LAST)
      rgn_d = smb_pkg::RGN_USB_PLUG;
    else if (top[7:6] == smb_pkg::SDRAM_BASE[31:30]
             || top[7:6] == smb_pkg::SDRAM_MIR_BASE[31:30])
    begin
      rgn_d = smb_pkg::RGN_SDRAM;
      idx_d = {1'b0, i_addr[smb_pkg::ARRAY_LSB+1:smb_pkg::ARRAY_LSB]};
    end
    else if (i_addr >= smb_pkg::MAC_BASE && i_addr <= smb_pkg::MAC_LAST)
      rgn_d = smb_pkg::RGN_MAC;
  end

  // Sequencer; USB receive moves win over CPU requests when idle
  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      state_q <= smb_pkg::ST_IDLE;
      cnt_q   <= 4'h0;
    end
    else
    begin
      case (state_q)
        smb_pkg::ST_IDLE:
          if (i_usb_rx_req)
            state_q <= smb_pkg::ST_ACT;
          else if (i_req && rgn_d == smb_pkg::RGN_NONE)
            state_q <= smb_pkg::ST_DONE;
          else if (i_req && rgn_d == smb_pkg::RGN_SDRAM)
            state_q <= smb_pkg::ST_ACT;
          else if (i_req)
            state_q <= smb_pkg::ST_CS;
        smb_pkg::ST_CS:
        begin
          state_q <= smb_pkg::ST_STROBE;
          cnt_q   <= smb_pkg::STROBE_CYC - 4'h1;
        end
        smb_pkg::ST_STROBE:
          if (cnt_q == 4'h0)
            state_q <= smb_pkg::ST_DONE;
          else
            cnt_q <= cnt_q - 4'h1;
        smb_pkg::ST_ACT:
        begin
          state_q <= smb_pkg::ST_RCD;
          cnt_q   <= tim_q[smb_pkg::TIM_RCD_LSB+:4];
        end
        smb_pkg::ST_RCD:
          if (cnt_q == 4'h0)
            state_q <= smb_pkg::ST_COL;
          else
            cnt_q <= cnt_q - 4'h1;
        smb_pkg::ST_COL:
          if (we_q)
            state_q <= smb_pkg::ST_PRE;
          else
          begin
            state_q <= smb_pkg::ST_CAS;
            cnt_q   <= tim_q[smb_pkg::TIM_CL_LSB+:4];
          end
        smb_pkg::ST_CAS:
          if (cnt_q == 4'h0)
            state_q <= smb_pkg::ST_PRE;
          else
            cnt_q <= cnt_q - 4'h1;
        smb_pkg::ST_PRE:
          state_q <= smb_pkg::ST_DONE;
        smb_pkg::ST_DONE:
          state_q <= smb_pkg::ST_IDLE;
        default:
          state_q <= smb_pkg::ST_IDLE;
      endcase
    end
  end

  // Request capture; held for the whole access so precharge keeps its bank
  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      addr_q  <= 32'h0000_0000;
      wdata_q <= 32'h0000_0000;
      be_q    <= 4'h0;
      we_q    <= 1'b0;
      usb_q   <= 1'b0;
      rgn_q   <= smb_pkg::RGN_NONE;
      idx_q   <= 3'h0;
      tim_q   <= 8'h00;
    end
    else if (state_q == smb_pkg::ST_IDLE && (i_usb_rx_req || i_req))
    begin
      tim_q <= i_dram_timing;
      usb_q <= i_usb_rx_req;
      if (i_usb_rx_req)
      begin
        addr_q <= {smb_pkg::SDRAM_BASE[31:24], i_usb_rx_addr};
        we_q   <= 1'b1;
        be_q   <= ~smb_pkg::USB_RX_DQM;
        rgn_q  <= smb_pkg::RGN_SDRAM;
        idx_q  <= 3'h0;
      end
      else
      begin
        addr_q  <= i_addr;
        wdata_q <= i_wdata;
        we_q    <= i_we;
        be_q    <= i_be;
        rgn_q   <= rgn_d;
        idx_q   <= idx_d;
      end
    end
  end

  // Read data; unused regions read as zero, writes there are dropped
  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
      rdata_q <= smb_pkg::RDATA_RST;
    else if (state_q == smb_pkg::ST_IDLE && i_req && !i_usb_rx_req)
      rdata_q <= smb_pkg::RDATA_RST;
    else if (state_q == smb_pkg::ST_STROBE && cnt_q == 4'h0 && !we_q)
      rdata_q <= i_periph_rdata;
    else if (state_q == smb_pkg::ST_CAS && cnt_q == 4'h0)
      rdata_q <= i_dram_data_bus;
  end

  // Interrupt from the USB controller is passed on, registered
  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
      irq_q <= 1'b0;
    else
      irq_q <= i_usb_irq;
  end

  assign o_external_irq_line_1 = irq_q;
  assign o_rdata               = rdata_q;
  assign o_ack                 = state_q == smb_pkg::ST_DONE && !usb_q;
  assign o_usb_rx_done         = state_q == smb_pkg::ST_DONE && usb_q;
  assign o_periph_addr         = addr_q[23:0];
  assign o_periph_wdata        = wdata_q;
  assign periph = state_q == smb_pkg::ST_CS || state_q == smb_pkg::ST_STROBE;

  // Peripheral selects: select one cycle ahead of the strobe
  always_comb
  begin
    o_rom_bank_select_n = 4'hF;
    o_func_block_select = 1'b0;
    o_io_bank_select_n  = 6'h3F;
    o_dma_io_select_n   = 4'hF;
    o_sram_select_n     = 3'h7;
    o_usb_csr_select_n  = 1'b1;
    o_usb_plug_select_n = 1'b1;
    o_mac_select_n      = 1'b1;
    o_rd_n              = !(state_q == smb_pkg::ST_STROBE && !we_q);
    o_wr_n              = !(state_q == smb_pkg::ST_STROBE && we_q);
    if (periph)
    begin
      case (rgn_q)
        smb_pkg::RGN_ROM:      o_rom_bank_select_n = ~(4'h1 << idx_q[1:0]);
        smb_pkg::RGN_FUNC:     o_func_block_select = 1'b1;
        smb_pkg::RGN_IO:       o_io_bank_select_n  = ~(6'h01 << idx_q);
        smb_pkg::RGN_DMA:      o_dma_io_select_n   = ~(4'h1 << idx_q[1:0]);
        smb_pkg::RGN_SRAM:     o_sram_select_n     = ~(3'h1 << idx_q[1:0]);
        smb_pkg::RGN_USB_CSR:  o_usb_csr_select_n  = 1'b0;
        smb_pkg::RGN_USB_PLUG: o_usb_plug_select_n = 1'b0;
        smb_pkg::RGN_MAC:      o_mac_select_n      = 1'b0;
        default:               o_func_block_select = 1'b0;
      endcase
    end
    // USB receive uses I/O bank 4 for the whole SDRAM move
    if (usb_q && state_q inside {smb_pkg::ST_ACT, smb_pkg::ST_RCD,
                                 smb_pkg::ST_COL, smb_pkg::ST_PRE})
      o_io_bank_select_n = 6'h2F;
  end

  // SDRAM commands; chip select is dropped on no-operation cycles
  always_comb
  begin
    o_sdram_cs_n           = 4'hF;
    o_ras_n                = 1'b1;
    o_cas_n                = 1'b1;
    o_dram_write_strobe_n  = 1'b1;
    o_dram_output_strobe_n = 1'b1;
    o_dqm                  = 4'hF;
    o_dram_addr_bus        = 12'h000;
    o_dram_ba              = addr_q[smb_pkg::BANK_LSB+:2];
    o_dram_data_bus        = wdata_q;
    o_dram_data_oe_n       = 1'b1;
    case (state_q)
      smb_pkg::ST_ACT:
      begin
        o_sdram_cs_n    = ~(4'h1 << idx_q[1:0]);
        o_ras_n         = 1'b0;
        o_dram_addr_bus = addr_q[smb_pkg::ROW_LSB+:12];
      end
      smb_pkg::ST_COL:
      begin
        o_sdram_cs_n           = ~(4'h1 << idx_q[1:0]);
        o_cas_n                = 1'b0;
        o_dram_addr_bus        = {4'h0, addr_q[smb_pkg::COL_LSB+:8]};
        o_dram_write_strobe_n  = !we_q;
        o_dram_output_strobe_n = we_q;
        o_dqm                  = we_q ? ~be_q : 4'h0;
        // Receive bytes come from the USB chip on lanes 31:24
        o_dram_data_oe_n = !(we_q && !usb_q);
        if (usb_q)
          o_dram_addr_bus[smb_pkg::USB_ADDR_BIT] = 1'b1;
      end
      smb_pkg::ST_CAS:
      begin
        o_dram_output_strobe_n = 1'b0;
        o_dqm                  = 4'h0;
      end
      smb_pkg::ST_PRE:
      begin
        o_sdram_cs_n          = ~(4'h1 << idx_q[1:0]);
        o_ras_n               = 1'b0;
        o_dram_write_strobe_n = 1'b0;
        o_dqm                 = 4'hF;
      end
      default:
        o_dqm = 4'hF;
    endcase
  end

  // Checks
  logic [1:0] col_ba_h;
  logic [4:0] gap_h;
  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      col_ba_h <= 2'h0;
      gap_h    <= 5'h00;
    end
    else
    begin
      if (!o_cas_n)
        col_ba_h <= o_dram_ba;
      gap_h <= (state_q == smb_pkg::ST_ACT) ? 5'h01 : gap_h + 5'h01;
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);

  property p_rom_cs_first;
    $fell(o_rd_n) && rgn_q == smb_pkg::RGN_ROM |-> $past(o_rom_bank_select_n) != 4'hF;
  endproperty
  a_rom_cs_first: assert property (p_rom_cs_first) else $error("rom strobe before select");
  property p_rom_bank;
    state_q == smb_pkg::ST_IDLE && i_req && !i_usb_rx_req && i_addr[31:24] == 8'h03
      |-> ##1 o_rom_bank_select_n == 4'h7 ##1 !o_rd_n;
  endproperty
  a_rom_bank: assert property (p_rom_bank) else $error("rom bank 3 decode wrong");
  property p_func;
    state_q == smb_pkg::ST_IDLE && i_req && !i_usb_rx_req && i_addr[31:28] == 4'h1
      |-> ##1 o_func_block_select [*3] ##1 !o_func_block_select;
  endproperty
  a_func: assert property (p_func) else $error("function block select wrong");
  property p_dma;
    state_q == smb_pkg::ST_IDLE && i_req && !i_usb_rx_req && i_addr[31:24] == 8'h26
      |-> ##1 o_dma_io_select_n == 4'hE && o_io_bank_select_n == 6'h3F;
  endproperty
  a_dma: assert property (p_dma) else $error("dma bank 0 decode wrong");
  property p_sram;
    state_q == smb_pkg::ST_IDLE && i_req && !i_usb_rx_req && i_addr[31:24] == 8'h32
      |-> ##1 o_sram_select_n == 3'h3;
  endproperty
  a_sram: assert property (p_sram) else $error("sram region 2 decode wrong");
  property p_unused;
    state_q == smb_pkg::ST_IDLE && i_req && !i_usb_rx_req && rgn_d == smb_pkg::RGN_NONE
      |-> ##1 o_ack && o_rdata == 32'h0 && o_mac_select_n && o_usb_plug_select_n;
  endproperty
  a_unused: assert property (p_unused) else $error("unused access misbehaves");
  property p_mirror;
    state_q == smb_pkg::ST_IDLE && i_req && !i_usb_rx_req && i_addr[31:28] == 4'hB
      |-> ##1 o_sdram_cs_n == 4'h7 && !o_ras_n;
  endproperty
  a_mirror: assert property (p_mirror) else $error("sdram mirror decode wrong");
  property p_one_array;
    $countones(~o_sdram_cs_n) <= 1;
  endproperty
  a_one_array: assert property (p_one_array) else $error("two sdram arrays selected");
  property p_strobes;
    !o_dram_output_strobe_n |-> o_dram_write_strobe_n && o_ras_n;
  endproperty
  a_strobes: assert property (p_strobes) else $error("read and write strobes clash");
  property p_rcd;
    !o_cas_n |-> gap_h == 5'(tim_q[smb_pkg::TIM_RCD_LSB+:4]) + 5'h02;
  endproperty
  a_rcd: assert property (p_rcd) else $error("column phase at wrong time");
  property p_nop_cs;
    o_ras_n && o_cas_n && o_dram_write_strobe_n |-> o_sdram_cs_n == 4'hF;
  endproperty
  a_nop_cs: assert property (p_nop_cs) else $error("select held on no-op");
  property p_pre_bank;
    !o_ras_n && !o_dram_write_strobe_n |-> o_dram_ba == col_ba_h;
  endproperty
  a_pre_bank: assert property (p_pre_bank) else $error("precharge bank differs");
  property p_pre_dqm;
    !o_cas_n && !o_dram_write_strobe_n |-> ##1 !o_ras_n && o_dqm == 4'hF;
  endproperty
  a_pre_dqm: assert property (p_pre_dqm) else $error("write precharge not masked");
  property p_usb_col;
    !o_cas_n && usb_q |-> o_dram_addr_bus[11] && o_dqm == 4'h7 && !o_io_bank_select_n[4]
      && o_dram_data_oe_n;
  endproperty
  a_usb_col: assert property (p_usb_col) else $error("usb receive column wrong");
  property p_irq;
    i_usb_irq |=> o_external_irq_line_1;
  endproperty
  a_irq: assert property (p_irq) else $error("usb interrupt not forwarded");

  c_rom_read: cover property (!o_rd_n && o_rom_bank_select_n == 4'hE);
  c_sdram_read: cover property (state_q == smb_pkg::ST_CAS ##1 state_q == smb_pkg::ST_PRE);
  c_usb_move: cover property (o_usb_rx_done);
  c_unused: cover property (o_ack && rgn_q == smb_pkg::RGN_NONE);

endmodule : smb_decode

/* test/smb_far_model.sv */
// Far-side model: flash and peripheral data, SDRAM array and USB node
module smb_far_model (
  input  wire logic        i_clock,
  input  wire logic        i_nrst,
  input  wire logic        i_rd_n,
  input  wire logic [23:0] i_periph_addr,
  output logic      [31:0] o_periph_rdata,
  input  wire logic        i_ras_n,
  input  wire logic        i_cas_n,
  input  wire logic        i_we_n,
  input  wire logic        i_oe_n,
  input  wire logic [3:0]  i_dqm,
  input  wire logic [11:0] i_addr_bus,
  input  wire logic [1:0]  i_ba,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wdata_oe_n,
  output logic      [31:0] o_dram_rdata,
  input  wire logic [7:0]  i_usb_byte,
  input  wire logic        i_arrive,
  input  wire logic        i_done,
  output logic             o_usb_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem_q [0:1023];
  logic [31:0] wd;
  logic [9:0]  rd_idx_q;
  logic        tog_q;

  initial
  begin
    for (int i = 0; i < 1024; i++)
      mem_q[i] = 32'h0;
  end

  // Released lines flip every cycle so a stale value never passes as data
  always_ff @(posedge i_clock or negedge i_nrst)
    if (!i_nrst)
      tog_q <= 1'b0;
    else
      tog_q <= ~tog_q;

  // Flash answers only while its read strobe is low
  assign o_periph_rdata = !i_rd_n ? {8'hA5, i_periph_addr} : {32{tog_q}};

  // USB node drives lane 31:24 only when the device leaves the bus
  assign wd = i_wdata_oe_n ? {i_usb_byte, {24{tog_q}}} : i_wdata;

  // Column write with byte masks; row is ignored, tests use distinct bank and column pairs
  always @(posedge i_clock)
  begin
    if (!i_cas_n && i_ras_n && !i_we_n)
      for (int b = 0; b < 4; b++)
        if (!i_dqm[b])
          mem_q[{i_ba, i_addr_bus[7:0]}][8*b +: 8] <= wd[8*b +: 8];
    if (!i_cas_n && i_ras_n && i_we_n)
      rd_idx_q <= {i_ba, i_addr_bus[7:0]};
  end
  assign o_dram_rdata = !i_oe_n ? mem_q[rd_idx_q] : {32{tog_q}};

  // Receive interrupt held until the move has been done
  always_ff @(posedge i_clock or negedge i_nrst)
    if (!i_nrst)
      o_usb_irq <= 1'b0;
    else if (i_arrive)
      o_usb_irq <= 1'b1;
    else if (i_done)
      o_usb_irq <= 1'b0;
endmodule : smb_far_model

/* test/smb_decode_tb.sv */
// Self-checking bench for the system memory bus decoder
module smb_decode_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [31:0] addr; logic [4:0] idx; logic [3:0] lat;} smb_row_t;
  logic        clock, nrst, req, we, ack, urx_req, urx_done, usb_irq, ext_irq, fblk;
  logic        rd_n, wr_n, ras_n, cas_n, we_n, oe_n, d_oe_n, usbcsr_n, plug_n, mac_n, arrive;
  logic [31:0] addr, wdata, rdata, pwdata, prdata, ddata, drdata, got;
  logic [3:0]  be, rom_n, dma_n, cs_n, dqm, pre_dqm, col_dqm;
  logic [7:0]  timing, usb_byte;
  logic [23:0] paddr;
  logic [5:0]  io_n;
  logic [2:0]  sram_n;
  logic [11:0] abus, col_a;
  logic [1:0]  ba, act_ba, pre_ba;
  logic [24:0] sel_now, seen, exp_sel;
  logic        col_we, saw_oe;
  int          fail_count, checks, lat, first_sel, first_rd, wr_low;
  smb_row_t    rows [18] = '{
    '{32'h0000_0000, 5'h00, 4'h4}, '{32'h03FF_FFFC, 5'h03, 4'h4},
    '{32'h0400_0000, 5'h1F, 4'h1}, '{32'h1000_0000, 5'h04, 4'h4},
    '{32'h2000_0000, 5'h05, 4'h4}, '{32'h25FF_FFFC, 5'h0A, 4'h4},
    '{32'h2600_0000, 5'h0B, 4'h4}, '{32'h2900_0000, 5'h0E, 4'h4},
    '{32'h2A00_0000, 5'h1F, 4'h1}, '{32'h3000_0000, 5'h0F, 4'h4},
    '{32'h3200_0000, 5'h11, 4'h4}, '{32'h3800_0000, 5'h12, 4'h4},
    '{32'h3900_03FC, 5'h13, 4'h4}, '{32'h3900_0400, 5'h1F, 4'h1},
    '{32'h4000_0000, 5'h15, 4'h6}, '{32'hB000_0010, 5'h18, 4'h6},
    '{32'hC000_07FC, 5'h14, 4'h4}, '{32'hC000_0800, 5'h1F, 4'h1}};

  // Active selects gathered into one vector, bit order fixed by the table
  assign sel_now = {~cs_n, ~mac_n, ~plug_n, ~usbcsr_n, ~sram_n, ~dma_n, ~io_n, fblk, ~rom_n};

  initial clock = 1'b0;
  always #50 clock = ~clock;

  smb_decode dut (.i_clock(clock), .i_nrst(nrst), .i_req(req), .i_we(we), .i_addr(addr),
    .i_wdata(wdata), .i_be(be), .o_ack(ack), .o_rdata(rdata), .i_dram_timing(timing),
    .i_usb_rx_req(urx_req), .i_usb_rx_addr(addr[23:0]), .o_usb_rx_done(urx_done),
    .i_usb_irq(usb_irq), .o_external_irq_line_1(ext_irq), .o_rom_bank_select_n(rom_n),
    .o_func_block_select(fblk), .o_io_bank_select_n(io_n), .o_dma_io_select_n(dma_n),
    .o_sram_select_n(sram_n), .o_usb_csr_select_n(usbcsr_n), .o_usb_plug_select_n(plug_n),
    .o_mac_select_n(mac_n), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_periph_addr(paddr),
    .o_periph_wdata(pwdata), .i_periph_rdata(prdata), .o_sdram_cs_n(cs_n), .o_ras_n(ras_n),
    .o_cas_n(cas_n), .o_dram_write_strobe_n(we_n), .o_dram_output_strobe_n(oe_n),
    .o_dqm(dqm), .o_dram_addr_bus(abus), .o_dram_ba(ba), .o_dram_data_bus(ddata),
    .o_dram_data_oe_n(d_oe_n), .i_dram_data_bus(drdata));

  smb_far_model far (.i_clock(clock), .i_nrst(nrst), .i_rd_n(rd_n), .i_periph_addr(paddr),
    .o_periph_rdata(prdata), .i_ras_n(ras_n), .i_cas_n(cas_n), .i_we_n(we_n), .i_oe_n(oe_n),
    .i_dqm(dqm), .i_addr_bus(abus), .i_ba(ba), .i_wdata(ddata), .i_wdata_oe_n(d_oe_n),
    .o_dram_rdata(drdata), .i_usb_byte(usb_byte), .i_arrive(arrive), .i_done(urx_done),
    .o_usb_irq(usb_irq));

  task automatic check(input logic [31:0] val, input logic [31:0] exp);
    checks++;
    if (val !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, val, exp);
    end
  endtask : check

  task automatic complete_run;
    $display("Counts: %0d checks, %0d mismatches", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run

  // One access held until its answer; bus activity is logged on the way
  task automatic run(input logic usb, input logic wr, input logic [31:0] a,
                     input logic [31:0] wd, input logic [3:0] b, input logic [7:0] tim);
    {seen, lat, first_sel, first_rd, wr_low, saw_oe} = '0;
    {we, addr, wdata, be, timing} = {wr, a, wd, b, tim};
    if (usb)
      urx_req = 1'b1;
    else
      req = 1'b1;
    for (int k = 1; k <= 40 && lat == 0; k++)
    begin
      @(negedge clock);
      seen |= sel_now;
      if (sel_now != 0 && first_sel == 0)
        first_sel = k;
      if (rd_n === 1'b0 && first_rd == 0)
        first_rd = k;
      if (wr_n === 1'b0)
        wr_low++;
      if ({ras_n, cas_n, we_n} === 3'h3)
        act_ba = ba;
      if ({ras_n, cas_n, we_n} === 3'h2)
        {pre_ba, pre_dqm} = {ba, dqm};
      if ({ras_n, cas_n} === 2'h2)
        {col_a, col_dqm, col_we} = {abus, dqm, we_n};
      if (oe_n === 1'b0)
        saw_oe = 1'b1;
      if ((usb ? urx_done : ack) === 1'b1)
        lat = k;
    end
    got = rdata;
    {req, urx_req} = 2'h0;
    if (lat == 0)
    begin
      fail_count++;
      complete_run();
    end
    @(negedge clock);
  endtask : run

  initial
  begin
    {nrst, req, we, urx_req, arrive} = '0;
    {addr, wdata, be, timing, usb_byte} = '0;
    {fail_count, checks} = '0;
    repeat (20) @(negedge clock);
    check(sel_now, 25'h0);
    check({dqm, d_oe_n, ack, ext_irq}, 7'h7C);
    $display("test reset values done");
    nrst = 1'b1;
    @(negedge clock);
    // Every region at least once, at bank starts and at last words
    foreach (rows[r])
    begin
      run(1'b0, 1'b0, rows[r].addr, 32'h0, 4'hF, 8'h00);
      exp_sel = (rows[r].idx == 5'h1F) ? 25'h0 : 25'h1 << rows[r].idx;
      check(seen, exp_sel);
      if (rows[r].lat != 4'h0)
      begin
        check(lat, rows[r].lat);
        check(got, rows[r].lat == 4'h4 ? {8'hA5, rows[r].addr[23:0]} : 32'h0);
      end
      if (rows[r].lat == 4'h4)
        check(first_rd, first_sel + 1);
      $display("test region %0d at %h done", r, rows[r].addr);
    end
    // Peripheral write: write strobe low for two cycles, no read strobe, read data cleared
    run(1'b0, 1'b1, 32'h2400_0010, 32'h5A5A_0123, 4'hF, 8'h00);
    check(lat, 4);
    check(seen, 25'h1 << 9);
    check(wr_low, 2);
    check(first_rd, 0);
    check(pwdata, 32'h5A5A_0123);
    check(paddr, 32'h0000_0010);
    check(got, 32'h0);
    $display("test peripheral write done");
    // Masked write then read, slow timing, bank 3 of array 1
    run(1'b0, 1'b1, 32'h50C0_0040, 32'h1122_3344, 4'h5, 8'h12);
    check(lat, 7);
    check(seen, 25'h1 << 22);
    check({col_we, col_dqm}, 5'h0A);
    check({pre_ba, pre_dqm}, {act_ba, 4'hF});
    run(1'b0, 1'b0, 32'h50C0_0040, 32'h0, 4'hF, 8'h12);
    check(lat, 9);
    check(got, 32'h0022_0044);
    check(saw_oe, 1'b1);
    check(pre_ba, act_ba);
    $display("test sdram timing done");
    // USB receive: interrupt, byte move, read back by the CPU
    {arrive, usb_byte} = {1'b1, 8'h9C};
    repeat (2) @(negedge clock);
    check(ext_irq, 1'b1);
    arrive = 1'b0;
    @(negedge clock);
    run(1'b1, 1'b1, 32'h0000_0040, 32'h0, 4'h0, 8'h00);
    check(lat, 5);
    check(seen, (25'h1 << 21) | (25'h1 << 9));
    check({col_a[11], col_dqm}, 5'h17);
    run(1'b0, 1'b0, 32'h4000_0040, 32'h0, 4'hF, 8'h00);
    check(got, 32'h9C00_0000);
    check(ext_irq, 1'b0);
    $display("test usb move done");
    // Reset in mid-fetch, then a clean fetch
    {req, addr} = {1'b1, 32'h0};
    repeat (3) @(negedge clock);
    {nrst, req} = 2'h0;
    @(negedge clock);
    check({sel_now, rd_n, ack}, {25'h0, 2'h2});
    nrst = 1'b1;
    @(negedge clock);
    run(1'b0, 1'b0, 32'h0000_0008, 32'h0, 4'hF, 8'h00);
    check(lat, 4);
    check(got, 32'hA500_0008);
    $display("test second reset done");
    complete_run();
  end
endmodule : smb_decode_tb
